// ==== tb/mfms_feedback_model.sv ====
`timescale 1ns/1ps
// ****
// Feedback devices
// ****
module mfms_feedback_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Fitted option modules
	input wire logic [2:0] i_fitted,
	// Positions and slot feedback flags
	output logic [15:0] o_drive_pos,
	output logic [15:0] o_option_slot_one_source_pos,
	output logic [15:0] o_option_slot_two_source_pos,
	output logic [15:0] o_option_slot_three_source_pos,
	output logic [2:0] o_slot_has_feedback
);
	// aligned at zero, forward rotation counts up
	// Distinct rates so a wrong selection cannot pass
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_drive_pos <= 16'h0000;
			o_option_slot_one_source_pos <= 16'h0000;
			o_option_slot_two_source_pos <= 16'h0000;
			o_option_slot_three_source_pos <= 16'h0000;
		end else begin
			o_drive_pos <= o_drive_pos + 16'h0003;
			o_option_slot_one_source_pos <= o_option_slot_one_source_pos + 16'h0005;
			o_option_slot_two_source_pos <= o_option_slot_two_source_pos + 16'h0007;
			o_option_slot_three_source_pos <= o_option_slot_three_source_pos + 16'h000B;
		end
	end
	assign o_slot_has_feedback = i_fitted;
endmodule

// ==== tb/mfms_top_asserts.sv ====
`timescale 1ns/1ps
module mfms_top_asserts (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Inputs watched
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [15:0] i_drive_pos,
	input wire logic [2:0] i_slot_has_feedback,
	input wire logic i_enc_freq_over,
	input wire logic i_drive_enabled,
	// Outputs watched
	input wire logic o_waitrequest,
	input wire logic [1:0] o_submode,
	input wire logic o_use_position_feedback,
	input wire logic o_speed_limit_check,
	input wire logic o_sample_rate_halved,
	input wire logic [1:0] o_active_source,
	input wire logic o_missing_feedback_module_trip,
	input wire logic o_enc_freq_trip,
	input wire logic [15:0] o_position
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	fb_by_mode_a: assert property (o_use_position_feedback == !o_submode[0])
		else $error("feedback use does not follow sub-mode");
	limit_by_mode_a: assert property (o_speed_limit_check == !o_submode[1])
		else $error("limit check does not follow sub-mode");
	freq_trip_set_a: assert property (i_enc_freq_over ##1 o_speed_limit_check |-> o_enc_freq_trip)
		else $error("frequency trip not raised");
	freq_trip_off_a: assert property (!o_enc_freq_trip && !o_speed_limit_check ##1 !o_speed_limit_check |-> !o_enc_freq_trip)
		else $error("frequency trip raised without limit check");
	halved_nofb_a: assert property (o_sample_rate_halved |-> !o_use_position_feedback)
		else $error("sample rate halved with feedback in use");
	source_hold_a: assert property (i_drive_enabled ##1 i_drive_enabled |=> $stable(o_active_source))
		else $error("source changed while enabled");
	module_trip_a: assert property (o_active_source != 2'h0 && !i_slot_has_feedback[o_active_source - 2'h1] |-> ##[0:1] o_missing_feedback_module_trip)
		else $error("missing module trip not raised");
	bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer not one cycle after request");
	pos_follow_a: assert property (o_active_source == 2'h0 [*3] |-> o_position == $past(i_drive_pos, 2))
		else $error("position does not follow drive encoder");
endmodule
bind mfms_top mfms_top_asserts i_chk (.i_clk, .i_rst_n, .i_read, .i_write, .i_drive_pos,
	.i_slot_has_feedback, .i_enc_freq_over, .i_drive_enabled, .o_waitrequest, .o_submode,
	.o_use_position_feedback, .o_speed_limit_check, .o_sample_rate_halved, .o_active_source,
	.o_missing_feedback_module_trip, .o_enc_freq_trip, .o_position);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb
	import mfms_pkg::*;
();
	// Short periods keep the run brief
	localparam int FAST = 8;
	localparam int SLOW = 16;
	localparam int RATE [4] = '{3, 5, 7, 11};
	localparam logic [31:0] DEF_ENC = {9'h000, MFMS_SWF_DEFAULT, 1'b0, MFMS_TYPE_DEFAULT,
		MFMS_LINES_DEFAULT};
	localparam logic [2:0] TYP [4] = '{3'h6, 3'h6, 3'h7, 3'h0};
	localparam logic [11:0] PH_IN [4] = '{12'h4D2, 12'hFA0, 12'h100, 12'hFFF};
	localparam logic [11:0] PH_EXP [4] = '{12'h4D2, 12'hE0F, 12'h100, 12'hE0F};
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [4:0] i_address = 5'h00;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h00000000;
	logic i_enc_freq_over = 1'b0;
	logic [3:0] i_pole_pairs = 4'h3;
	logic i_drive_enabled = 1'b0;
	logic i_phasing_done = 1'b0;
	logic [11:0] i_phasing_angle = 12'h000;
	logic [2:0] fitted = 3'h3;
	logic [15:0] drv, s1, s2, s3, o_speed, o_position, o_flux_position;
	logic [2:0] has_fb;
	logic [31:0] o_readdata, rd;
	logic [1:0] o_submode, o_active_source;
	logic o_waitrequest, o_use_position_feedback, o_speed_limit_check, o_sample_tick;
	logic o_sample_rate_halved, o_missing_feedback_module_trip, o_enc_freq_trip;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int m;
	mfms_feedback_model i_fb (.i_clk, .i_rst_n, .i_fitted(fitted), .o_drive_pos(drv),
		.o_option_slot_one_source_pos(s1), .o_option_slot_two_source_pos(s2), .o_option_slot_three_source_pos(s3), .o_slot_has_feedback(has_fb));
	mfms_top #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) i_dut (.i_clk, .i_rst_n, .i_address,
		.i_read, .i_write, .i_writedata, .i_byteenable(4'hF), .o_readdata, .o_waitrequest,
		.i_drive_pos(drv), .i_option_slot_one_source_pos(s1), .i_option_slot_two_source_pos(s2), .i_option_slot_three_source_pos(s3),
		.i_slot_has_feedback(has_fb), .i_enc_freq_over, .i_pole_pairs, .i_drive_enabled,
		.i_phasing_done, .i_phasing_angle, .o_submode, .o_use_position_feedback,
		.o_speed_limit_check, .o_sample_tick, .o_sample_rate_halved, .o_active_source,
		.o_missing_feedback_module_trip, .o_enc_freq_trip, .o_speed, .o_position,
		.o_flux_position);
	initial forever #2.5 i_clk = ~i_clk;
	// ****
	// Shared tasks
	// ****
	task automatic report_and_stop();
		$display("Compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_address <= a;
		i_writedata <= d;
		i_write <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		i_write <= 1'b0;
	endtask
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_address <= a;
		i_read <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		d = o_readdata;
		i_read <= 1'b0;
	endtask
	task automatic wait_ticks(input int n);
		repeat (n) @(posedge i_clk iff o_sample_tick === 1'b1);
	endtask
	task automatic chk_period(input int exp);
		int c;
		c = 0;
		@(posedge i_clk iff o_sample_tick === 1'b1);
		do begin
			@(posedge i_clk);
			c++;
		end while (o_sample_tick !== 1'b1);
		chk("tick period", 32'(exp), 32'(c));
	endtask
	// Input sampled at one edge shows two edges later
	task automatic chk_path(input int src, input logic [11:0] ph);
		logic [15:0] p;
		logic [31:0] f;
		@(posedge i_clk);
		p = src == 0 ? drv : src == 1 ? s1 : src == 2 ? s2 : s3;
		f = 32'(p) * 32'(i_pole_pairs) + ((32'(ph) * 32'(MFMS_PHASE_SCALE)) >> MFMS_PHASE_SHIFT);
		repeat (2) @(posedge i_clk);
		chk("position", 32'(p), 32'(o_position));
		chk("flux", 32'(f[15:0]), 32'(o_flux_position));
		chk("speed", 32'(RATE[src] * FAST), 32'(o_speed));
	endtask
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		bus_rd(MFMS_REG_PHASE, rd);
		chk("phase reset", 32'(MFMS_PHASE_FACTORY), rd);
		bus_rd(MFMS_REG_ENCCFG, rd);
		chk("enc cfg reset", DEF_ENC, rd);
		bus_wr(5'h02, 32'hFFFFFFFF);
		bus_rd(5'h02, rd);
		chk("unaligned read", 32'h0, rd);
		// over-limit held while ceiling is tested, sub-mode 3 last
		i_enc_freq_over <= 1'b1;
		for (m = 0; m < 4; m++) begin
			bus_wr(MFMS_REG_MODE, 32'(m));
			bus_wr(MFMS_REG_CMD, 32'h4);
			wait_ticks(2);
			chk("submode", 32'(m), 32'(o_submode));
			chk("use feedback", 32'(m % 2 == 0), 32'(o_use_position_feedback));
			chk("limit check", 32'(m < 2), 32'(o_speed_limit_check));
			chk("freq trip", 32'(m < 2), 32'(o_enc_freq_trip));
			chk("halved", 32'(m % 2), 32'(o_sample_rate_halved));
			chk_period(m % 2 == 1 ? SLOW : FAST);
		end
		i_enc_freq_over <= 1'b0;
		bus_wr(MFMS_REG_MODE, 32'h1);
		for (m = 0; m < 3; m++) begin
			bus_wr(MFMS_REG_ENCCFG, {9'h000, 3'(m * 2), 1'b0, 3'h0, 16'h0400});
			wait_ticks(2);
			chk("halved by switching", 32'(m > 0), 32'(o_sample_rate_halved));
		end
		for (m = 0; m < 4; m++) begin
			bus_wr(MFMS_REG_ENCCFG, {9'h000, MFMS_SWF_6K, 1'b0, TYP[m],
				m == 1 ? 16'h0400 : 16'h03E8});
			wait_ticks(2);
			bus_rd(MFMS_REG_STATUS, rd);
			chk("forced flag", 32'(m % 2 == 0), 32'(rd[MFMS_ST_FORCED_BIT]));
			chk("forced submode", 32'(m % 2), 32'(o_submode));
		end
		bus_wr(MFMS_REG_CMD, 32'h1);
		bus_rd(MFMS_REG_ENCCFG, rd);
		chk("enc cfg user default", DEF_ENC, rd);
		for (m = 0; m < 4; m++) begin
			if (m < 2) begin
				bus_wr(MFMS_REG_PHASE, 32'(PH_IN[m]));
			end else begin
				@(posedge i_clk);
				i_phasing_done <= 1'b1;
				i_phasing_angle <= PH_IN[m];
				@(posedge i_clk);
				i_phasing_done <= 1'b0;
			end
			bus_rd(MFMS_REG_PHASE, rd);
			chk("phase", 32'(PH_EXP[m]), rd);
			chk_path(0, PH_EXP[m]);
		end
		bus_wr(MFMS_REG_CMD, 32'h1);
		bus_rd(MFMS_REG_PHASE, rd);
		chk("phase after user default", 32'h00000E0F, rd);
		bus_wr(MFMS_REG_CMD, 32'h2);
		bus_rd(MFMS_REG_PHASE, rd);
		chk("phase after factory", 32'h0, rd);
		i_drive_enabled <= 1'b1;
		bus_wr(MFMS_REG_FBSEL, 32'h1);
		bus_rd(MFMS_REG_FBSEL, rd);
		chk("source pending", 32'h00000101, rd);
		chk("source held", 32'h0, 32'(o_active_source));
		i_drive_enabled <= 1'b0;
		for (m = 0; m < 4; m++) begin
			bus_wr(MFMS_REG_FBSEL, 32'(m));
			wait_ticks(3);
			chk("active source", 32'(m), 32'(o_active_source));
			chk_path(m, 12'h000);
			chk("module trip", 32'(m == 3), 32'(o_missing_feedback_module_trip));
		end
		fitted <= 3'h7;
		bus_wr(MFMS_REG_CMD, 32'h4);
		repeat (2) @(posedge i_clk);
		chk("module trip cleared", 32'h0, 32'(o_missing_feedback_module_trip));
		report_and_stop();
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
endmodule

// ==== verilog/mfms_fb_if.sv ====
`timescale 1ns/1ps
interface mfms_fb_if;
	logic [1:0] source;
	logic sample_tick;
	logic [15:0] drive_pos;
	logic [15:0] option_slot_one_source_pos;
	logic [15:0] option_slot_two_source_pos;
	logic [15:0] option_slot_three_source_pos;
	logic [3:0] pole_pairs;
	logic [11:0] phase;
	logic [15:0] speed;
	logic [15:0] position;
	logic [15:0] flux;

	modport ctrl (
		output source, sample_tick, drive_pos, option_slot_one_source_pos, option_slot_two_source_pos, option_slot_three_source_pos,
		output pole_pairs, phase,
		input speed, position, flux
	);
	modport path (
		input source, sample_tick, drive_pos, option_slot_one_source_pos, option_slot_two_source_pos, option_slot_three_source_pos,
		input pole_pairs, phase,
		output speed, position, flux
	);
endinterface

// ==== verilog/mfms_feedback_path.sv ====
`timescale 1ns/1ps
module mfms_feedback_path
	import mfms_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Feedback channel
	mfms_fb_if.path fb
);

	// ******************************
	// Source selection
	// ******************************
	logic [15:0] prev_pos;
	logic [1:0] prev_src;
	wire logic [15:0] sel_pos;
	wire logic [15:0] delta;
	wire logic [15:0] phase16;
	wire logic [19:0] elec_pos;
	wire logic src_changed;

	function automatic logic [15:0] phase_to_turn(input logic [11:0] tenths);
		logic [27:0] prod;
		prod = 28'(tenths) * 28'(MFMS_PHASE_SCALE);
		return prod[MFMS_PHASE_SHIFT +: 16];
	endfunction

	// [R12] slot mapping
	assign sel_pos = (fb.source == MFMS_SRC_OPTION_SLOT_ONE_SOURCE) ? fb.option_slot_one_source_pos :
		(fb.source == MFMS_SRC_OPTION_SLOT_TWO_SOURCE) ? fb.option_slot_two_source_pos :
		(fb.source == MFMS_SRC_OPTION_SLOT_THREE_SOURCE) ? fb.option_slot_three_source_pos : fb.drive_pos;
	// [R10] forward is positive
	assign delta = sel_pos - prev_pos;
	assign phase16 = phase_to_turn(fb.phase);
	assign elec_pos = 20'(sel_pos) * 20'(fb.pole_pairs);
	assign src_changed = fb.source != prev_src;

	// ******************************
	// Speed and flux position
	// ******************************
	// [R13] one source feeds both
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prev_pos <= 16'h0000;
			prev_src <= MFMS_SRC_DRIVE;
			fb.speed <= 16'h0000;
			fb.position <= 16'h0000;
			fb.flux <= 16'h0000;
		end else begin
			prev_src <= fb.source;
			fb.position <= sel_pos;
			// [R7] offset applies at once
			fb.flux <= elec_pos[15:0] + phase16;
			// Re-seed on a source swap so no false speed spike appears
			if (src_changed) begin
				prev_pos <= sel_pos;
				fb.speed <= 16'h0000;
			end else if (fb.sample_tick) begin
				prev_pos <= sel_pos;
				fb.speed <= delta;
			end
		end
	end

endmodule

// ==== verilog/mfms_pkg.sv ====
package mfms_pkg;

	// ******************************
	// Register map (byte addresses)
	// ******************************
	localparam int MFMS_ADDR_W = 5;
	localparam logic [4:0] MFMS_REG_MODE = 5'h00;
	localparam logic [4:0] MFMS_REG_PHASE = 5'h04;
	localparam logic [4:0] MFMS_REG_FBSEL = 5'h08;
	localparam logic [4:0] MFMS_REG_ENCCFG = 5'h0C;
	localparam logic [4:0] MFMS_REG_STATUS = 5'h10;
	localparam logic [4:0] MFMS_REG_CMD = 5'h14;
	localparam logic [4:0] MFMS_REG_SPEED = 5'h18;
	localparam logic [4:0] MFMS_REG_POSITION = 5'h1C;

	// ******************************
	// Field positions
	// ******************************
	localparam int MFMS_ENC_LINES_LSB = 0;
	localparam int MFMS_ENC_TYPE_LSB = 16;
	localparam int MFMS_ENC_SWF_LSB = 20;
	localparam int MFMS_FB_ACTIVE_LSB = 4;
	localparam int MFMS_FB_PENDING_BIT = 8;
	localparam int MFMS_ST_FORCED_BIT = 0;
	localparam int MFMS_ST_NOFB_BIT = 1;
	localparam int MFMS_ST_CHECK_BIT = 2;
	localparam int MFMS_ST_TRIP_BIT = 3;
	localparam int MFMS_ST_FREQ_TRIP_BIT = 4;
	localparam int MFMS_ST_HALVED_BIT = 5;
	localparam int MFMS_ST_EFF_LSB = 8;
	localparam int MFMS_CMD_USER_DEF_BIT = 0;
	localparam int MFMS_CMD_FACTORY_BIT = 1;
	localparam int MFMS_CMD_CLR_TRIP_BIT = 2;

	// ******************************
	// Encodings
	// ******************************
	localparam logic [1:0] MFMS_SUB_FB = 2'h0;
	localparam logic [1:0] MFMS_SUB_NOFB = 2'h1;
	localparam logic [1:0] MFMS_SUB_FB_NOLIM = 2'h2;
	localparam logic [1:0] MFMS_SUB_NOFB_NOLIM = 2'h3;
	localparam logic [1:0] MFMS_SRC_DRIVE = 2'h0;
	localparam logic [1:0] MFMS_SRC_OPTION_SLOT_ONE_SOURCE = 2'h1;
	localparam logic [1:0] MFMS_SRC_OPTION_SLOT_TWO_SOURCE = 2'h2;
	localparam logic [1:0] MFMS_SRC_OPTION_SLOT_THREE_SOURCE = 2'h3;
	localparam logic [2:0] MFMS_ENC_SINE_COS_MIN = 3'h6;
	localparam logic [2:0] MFMS_SWF_6K = 3'h2;
	localparam logic [2:0] MFMS_SWF_12K = 3'h4;

	// ******************************
	// Reset and default values
	// ******************************
	localparam logic [15:0] MFMS_LINES_DEFAULT = 16'h0400;
	localparam logic [2:0] MFMS_TYPE_DEFAULT = 3'h0;
	localparam logic [2:0] MFMS_SWF_DEFAULT = 3'h2;
	localparam logic [11:0] MFMS_PHASE_FACTORY = 12'h000;
	localparam logic [11:0] MFMS_PHASE_MAX = 12'hE0F;
	localparam logic [15:0] MFMS_PHASE_SCALE = 16'h48D1;
	localparam int MFMS_PHASE_SHIFT = 10;

	// ******************************
	// Timing
	// ******************************
	localparam longint MFMS_CLK_HZ = 200000000;
	localparam longint MFMS_FAST_RATE_HZ = 12000;
	localparam longint MFMS_SLOW_RATE_HZ = 6000;
	localparam int MFMS_FAST_CYCLES = int'(MFMS_CLK_HZ / MFMS_FAST_RATE_HZ);
	localparam int MFMS_SLOW_CYCLES = int'(MFMS_CLK_HZ / MFMS_SLOW_RATE_HZ);

endpackage

// ==== verilog/mfms_top.sv ====
// Function
// [R1] Sub-mode 0 runs vector control on the chosen feedback, sub-mode 1 derives position inside.
// [R2] Sub-mode 2 uses feedback with no speed ceiling, sub-mode 3 runs without feedback or ceiling.
// [R3] In the sub-modes without a ceiling the encoder frequency limit is not checked.
// [R4] Software must move to sub-mode 3 before the encoder frequency limit is reached.
// [R5] A line count that is not a power of two with a sine-cosine encoder forces sub-mode 0.
// [R6] Without position feedback, 6 kHz and 12 kHz switching sample at 6 kHz instead of 12 kHz.
// [R7] A new phase offset takes effect at once and may be written at any time.
// [R8] A finished phasing test stores its measured angle as the phase offset.
// [R9] The phase offset resets to 0.0 and survives a user default load.
// [R10] Forward rotation shows positive speed and rising position.
// [R11] For zero offset the encoder is aligned to n times 65536 over the pole pair count.
// [R12] Source 0 is the drive encoder and sources 1 to 3 are option slots 1 to 3.
// [R13] The chosen source feeds both the speed controller and the flux position.
// [R14] Choosing a slot with no feedback module raises the missing module trip.
// [R15] A new source is applied only while the output is disabled and waits otherwise.
// [R16] The phase offset is kept in tenths of a degree and clamped to 0 to 359.9.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mfms_top
	import mfms_pkg::*;
#(
	parameter int FAST_CYCLES = MFMS_FAST_CYCLES,
	parameter int SLOW_CYCLES = MFMS_SLOW_CYCLES
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Avalon-MM slave
	input wire logic [MFMS_ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Feedback devices
	input wire logic [15:0] i_drive_pos,
	input wire logic [15:0] i_option_slot_one_source_pos,
	input wire logic [15:0] i_option_slot_two_source_pos,
	input wire logic [15:0] i_option_slot_three_source_pos,
	input wire logic [2:0] i_slot_has_feedback,
	input wire logic i_enc_freq_over,
	// Drive state
	input wire logic [3:0] i_pole_pairs,
	input wire logic i_drive_enabled,
	input wire logic i_phasing_done,
	input wire logic [11:0] i_phasing_angle,
	// Control outputs
	output logic [1:0] o_submode,
	output logic o_use_position_feedback,
	output logic o_speed_limit_check,
	output logic o_sample_tick,
	output logic o_sample_rate_halved,
	output logic [1:0] o_active_source,
	output logic o_missing_feedback_module_trip,
	output logic o_enc_freq_trip,
	// Feedback results
	output logic [15:0] o_speed,
	output logic [15:0] o_position,
	output logic [15:0] o_flux_position
);

	// Period counter is 16 bits wide and needs at least two states
	if (FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES || SLOW_CYCLES > 65535) begin
		$error("mfms_top: sample period parameters out of range");
	end

	// ******************************
	// Helpers
	// ******************************
	function automatic logic is_pow2(input logic [15:0] v);
		return (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [11:0] clamp_phase(input logic [11:0] v);
		return (v > MFMS_PHASE_MAX) ? MFMS_PHASE_MAX : v;
	endfunction

	// ******************************
	// Software state
	// ******************************
	logic [1:0] submode_req;
	logic [11:0] phase_offset;
	logic [1:0] fbsel_req;
	logic [1:0] fbsel_active;
	logic [15:0] encoder_line_count;
	logic [2:0] encoder_type_select;
	logic [2:0] switching_frequency_setting;
	logic [15:0] tick_cnt;

	// ******************************
	// Bus decode
	// ******************************
	wire logic bus_req;
	wire logic wr_ok;
	wire logic aligned;
	wire logic hit_mode;
	wire logic hit_phase;
	wire logic hit_fbsel;
	wire logic hit_enccfg;
	wire logic hit_cmd;
	wire logic [31:0] cur_enccfg;
	wire logic [31:0] new_enccfg;
	wire logic [31:0] new_mode;
	wire logic [31:0] new_phase;
	wire logic [31:0] new_fbsel;
	wire logic [31:0] new_cmd;
	wire logic user_default;
	wire logic factory_default;
	wire logic clear_trip;

	assign bus_req = i_read || i_write;
	// A write lands at the one edge where waitrequest is seen low
	assign wr_ok = i_write && !o_waitrequest;
	assign aligned = i_address[1:0] == 2'h0;
	assign hit_mode = wr_ok && aligned && i_address == MFMS_REG_MODE;
	assign hit_phase = wr_ok && aligned && i_address == MFMS_REG_PHASE;
	assign hit_fbsel = wr_ok && aligned && i_address == MFMS_REG_FBSEL;
	assign hit_enccfg = wr_ok && aligned && i_address == MFMS_REG_ENCCFG;
	assign hit_cmd = wr_ok && aligned && i_address == MFMS_REG_CMD;
	assign cur_enccfg = {9'h000, switching_frequency_setting, 1'b0, encoder_type_select,
		encoder_line_count};
	assign new_enccfg = be_merge(cur_enccfg, i_writedata, i_byteenable);
	assign new_mode = be_merge({30'h0, submode_req}, i_writedata, i_byteenable);
	assign new_phase = be_merge({20'h0, phase_offset}, i_writedata, i_byteenable);
	assign new_fbsel = be_merge({30'h0, fbsel_req}, i_writedata, i_byteenable);
	assign new_cmd = be_merge(32'h0, i_writedata, i_byteenable);
	assign user_default = hit_cmd && new_cmd[MFMS_CMD_USER_DEF_BIT];
	assign factory_default = hit_cmd && new_cmd[MFMS_CMD_FACTORY_BIT];
	assign clear_trip = hit_cmd && new_cmd[MFMS_CMD_CLR_TRIP_BIT];

	// ******************************
	// Mode derivation
	// ******************************
	wire logic force_zero;
	wire logic [1:0] next_submode;
	wire logic no_feedback;
	wire logic limit_check;
	wire logic sel_is_slot;
	wire logic slot_present;
	wire logic halve_rate;
	wire logic [15:0] period;

	// [R5] sine-cosine needs a power-of-two count
	assign force_zero = !is_pow2(encoder_line_count) &&
		(encoder_type_select >= MFMS_ENC_SINE_COS_MIN);
	assign next_submode = force_zero ? MFMS_SUB_FB : submode_req;
	// [R1] [R2] feedback or internal
	assign no_feedback = (next_submode == MFMS_SUB_NOFB) ||
		(next_submode == MFMS_SUB_NOFB_NOLIM);
	// [R3] no limit check
	assign limit_check = (next_submode == MFMS_SUB_FB) || (next_submode == MFMS_SUB_NOFB);
	// [R6] halved sample rate
	assign halve_rate = no_feedback && ((switching_frequency_setting == MFMS_SWF_6K) ||
		(switching_frequency_setting == MFMS_SWF_12K));
	assign period = halve_rate ? 16'(SLOW_CYCLES) : 16'(FAST_CYCLES);
	assign sel_is_slot = fbsel_active != MFMS_SRC_DRIVE;
	assign slot_present = (fbsel_active == MFMS_SRC_OPTION_SLOT_ONE_SOURCE) ? i_slot_has_feedback[0] :
		(fbsel_active == MFMS_SRC_OPTION_SLOT_TWO_SOURCE) ? i_slot_has_feedback[1] :
		(fbsel_active == MFMS_SRC_OPTION_SLOT_THREE_SOURCE) ? i_slot_has_feedback[2] : 1'b1;

	// ******************************
	// Configuration registers
	// ******************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || user_default || factory_default) begin
			submode_req <= MFMS_SUB_FB;
			encoder_line_count <= MFMS_LINES_DEFAULT;
			encoder_type_select <= MFMS_TYPE_DEFAULT;
			switching_frequency_setting <= MFMS_SWF_DEFAULT;
			fbsel_req <= MFMS_SRC_DRIVE;
		end else begin
			if (hit_mode) begin
				submode_req <= new_mode[1:0];
			end
			if (hit_enccfg) begin
				encoder_line_count <= new_enccfg[MFMS_ENC_LINES_LSB +: 16];
				encoder_type_select <= new_enccfg[MFMS_ENC_TYPE_LSB +: 3];
				switching_frequency_setting <= new_enccfg[MFMS_ENC_SWF_LSB +: 3];
			end
			if (hit_fbsel) begin
				fbsel_req <= new_fbsel[1:0];
			end
		end
	end

	// [R9] kept on user defaults
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || factory_default) begin
			phase_offset <= MFMS_PHASE_FACTORY;
		end else if (i_phasing_done) begin
			// [R8] test result wins over a write
			phase_offset <= clamp_phase(i_phasing_angle);
		end else if (hit_phase) begin
			// [R7] [R16] any time, clamped
			phase_offset <= clamp_phase(new_phase[11:0]);
		end
	end

	// [R15] apply while disabled
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			fbsel_active <= MFMS_SRC_DRIVE;
		end else if (!i_drive_enabled) begin
			fbsel_active <= fbsel_req;
		end
	end

	// ******************************
	// Sample timer
	// ******************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tick_cnt <= 16'h0000;
			o_sample_tick <= 1'b0;
		end else begin
			o_sample_tick <= tick_cnt >= period - 16'h0001;
			tick_cnt <= (tick_cnt >= period - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	// ******************************
	// Mode outputs and trips
	// ******************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_submode <= MFMS_SUB_FB;
			o_use_position_feedback <= 1'b1;
			o_speed_limit_check <= 1'b1;
			o_sample_rate_halved <= 1'b0;
			o_active_source <= MFMS_SRC_DRIVE;
		end else begin
			o_submode <= next_submode;
			o_use_position_feedback <= !no_feedback;
			o_speed_limit_check <= limit_check;
			o_sample_rate_halved <= halve_rate;
			o_active_source <= fbsel_active;
		end
	end

	// A fresh fault beats a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_missing_feedback_module_trip <= 1'b0;
			o_enc_freq_trip <= 1'b0;
		end else begin
			// [R14] empty slot trips
			if (sel_is_slot && !slot_present) begin
				o_missing_feedback_module_trip <= 1'b1;
			end else if (clear_trip) begin
				o_missing_feedback_module_trip <= 1'b0;
			end
			// [R3] [R4] frequency trip gated
			if (limit_check && i_enc_freq_over) begin
				o_enc_freq_trip <= 1'b1;
			end else if (clear_trip) begin
				o_enc_freq_trip <= 1'b0;
			end
		end
	end

	// ******************************
	// Feedback path
	// ******************************
	mfms_fb_if fb ();

	assign fb.source = fbsel_active;
	assign fb.sample_tick = o_sample_tick;
	assign fb.drive_pos = i_drive_pos;
	assign fb.option_slot_one_source_pos = i_option_slot_one_source_pos;
	assign fb.option_slot_two_source_pos = i_option_slot_two_source_pos;
	assign fb.option_slot_three_source_pos = i_option_slot_three_source_pos;
	assign fb.pole_pairs = i_pole_pairs;
	assign fb.phase = phase_offset;

	// [R13] shared source path
	mfms_feedback_path u_path (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.fb(fb.path)
	);

	// Results are re-timed so every output leaves a local flop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_speed <= 16'h0000;
			o_position <= 16'h0000;
			o_flux_position <= 16'h0000;
		end else begin
			o_speed <= fb.speed;
			o_position <= fb.position;
			o_flux_position <= fb.flux;
		end
	end

	// ******************************
	// Read mux and handshake
	// ******************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (aligned) begin
			unique case (i_address)
				MFMS_REG_MODE: rd_mux = {30'h0, submode_req};
				MFMS_REG_PHASE: rd_mux = {20'h0, phase_offset};
				MFMS_REG_FBSEL: begin
					rd_mux[1:0] = fbsel_req;
					rd_mux[MFMS_FB_ACTIVE_LSB +: 2] = fbsel_active;
					rd_mux[MFMS_FB_PENDING_BIT] = fbsel_req != fbsel_active;
				end
				MFMS_REG_ENCCFG: rd_mux = cur_enccfg;
				MFMS_REG_STATUS: begin
					rd_mux[MFMS_ST_FORCED_BIT] = force_zero;
					rd_mux[MFMS_ST_NOFB_BIT] = no_feedback;
					rd_mux[MFMS_ST_CHECK_BIT] = limit_check;
					rd_mux[MFMS_ST_TRIP_BIT] = o_missing_feedback_module_trip;
					rd_mux[MFMS_ST_FREQ_TRIP_BIT] = o_enc_freq_trip;
					rd_mux[MFMS_ST_HALVED_BIT] = halve_rate;
					rd_mux[MFMS_ST_EFF_LSB +: 2] = next_submode;
				end
				MFMS_REG_SPEED: rd_mux = {{16{o_speed[15]}}, o_speed};
				MFMS_REG_POSITION: rd_mux = {16'h0000, o_position};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// One wait cycle per access; the second edge completes it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h0000_0000;
		end else begin
			o_waitrequest <= !(bus_req && o_waitrequest);
			if (i_read && o_waitrequest) begin
				o_readdata <= rd_mux;
			end
		end
	end

endmodule
